// >>> rtl/rxddr_pkg.sv
package rxddr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_UNDERRUN = 4'h8;

  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CODE_BIT = 2;
  localparam int CTRL_CTC_BIT = 3;

  // Status fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_LEVEL_LSB = 4;
  localparam int STAT_EMPTY_BIT = 8;
  localparam int STAT_FULL_BIT = 9;

  // ----------------------------------------
  // Channel modes and reset values
  // ----------------------------------------
  localparam logic [1:0] MODE_NIBBLE = 2'h0;
  localparam logic [1:0] MODE_MUX = 2'h1;
  localparam logic [1:0] MODE_INDEP = 2'h2;
  localparam logic [1:0] MODE_RST = MODE_NIBBLE;
  localparam logic CODE_RST = 1'h0;
  localparam logic CTC_RST = 1'h1;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int WORD_W = 10;
  localparam int NUM_CH = 7;
  localparam int FIFO_DEPTH = 8;
  localparam int REF_PERIOD_NS = 40;
  localparam int REC_DIV = 10;
  localparam int REC_HALF = REC_DIV / 2;

  // Lane sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_FIRST = 3'h2,
    ST_SECOND = 3'h4
  } rxddr_state_e;

endpackage

// >>> rtl/rxddr_top.sv
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps

// ----------------------------------------
// Word FIFO
// ----------------------------------------
module rxddr_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [LW-1:0] cnt;
  } rxddr_fifo_s;

  rxddr_fifo_s s_q;
  rxddr_fifo_s s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.cnt != LW'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rd];
  assign level = s_q.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = (s_q.wr == PW'(DEPTH - 1)) ? '0 : s_q.wr + PW'(1);
    end
    if (pop) begin
      s_d.rd = (s_q.rd == PW'(DEPTH - 1)) ? '0 : s_q.rd + PW'(1);
    end
    s_d.cnt = s_q.cnt + LW'(push) - LW'(pop);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ----------------------------------------
// Receive A/B DDR output
// ----------------------------------------
module rxddr_top #(
  parameter int DEPTH = rxddr_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register bus
  input wire logic [rxddr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Received words
  input wire logic word_valid,
  output logic word_ready,
  input wire logic [rxddr_pkg::WORD_W-1:0] word_a,
  input wire logic [rxddr_pkg::WORD_W-1:0] word_b,
  input wire logic kflag_a,
  input wire logic kflag_b,
  // Recovered clocks, channels A to G
  input wire logic [rxddr_pkg::NUM_CH-1:0] rec_clk_in,
  // Receive clocks
  output logic chan_h_rx_clock_out,
  output logic [rxddr_pkg::NUM_CH-1:0] per_channel_rx_clock_out,
  // Receive lanes
  output logic [7:0] rx_lane_ab_byte,
  output logic rx_lane_ab_bit8_kflag,
  output logic rx_lane_ab_bit9
);
  localparam int W = rxddr_pkg::WORD_W;
  localparam int N = rxddr_pkg::NUM_CH;
  localparam int FW = 2 * W + 2;
  localparam int LW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] prev;
    logic [N-1:0][2:0] cnt;
    logic [N-1:0] div;
    logic shared;
    logic [N-1:0] pco;
    logic [W-1:0] lanes;
    rxddr_pkg::rxddr_state_e st;
    logic [W-1:0] cur_a;
    logic [W-1:0] cur_b;
    logic cur_ka;
    logic cur_kb;
    logic [1:0] mode;
    logic code;
    logic clock_tolerance_compensation;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] underruns;
  } rxddr_top_s;

  localparam rxddr_top_s RST = '{
    st: rxddr_pkg::ST_IDLE,
    mode: rxddr_pkg::MODE_RST,
    code: rxddr_pkg::CODE_RST,
    clock_tolerance_compensation: rxddr_pkg::CTC_RST,
    default: '0
  };

  rxddr_top_s s_q;
  rxddr_top_s s_d;

  logic f_valid;
  logic f_pop;
  logic [FW-1:0] f_data;
  logic [LW-1:0] f_level;
  logic ctc_eff;
  logic tick;
  logic first_slot;
  logic shared_nxt;

  // ----------------------------------------
  // Word buffer
  // ----------------------------------------
  rxddr_fifo #(
    .WIDTH(FW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .reset(reset),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .in_data({kflag_b, kflag_a, word_b, word_a}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data),
    .level(f_level)
  );

  // Lane pattern for one half of a nibble word
  function automatic logic [4:0] nib(input logic [W-1:0] w, input logic k,
                                     input logic hi, input logic code);
    logic [4:0] r;
    if (!code) begin
      r = hi ? w[9:5] : w[4:0];
    end else begin
      r = hi ? {w[7], k, w[6:4]} : {1'b0, w[3:0]};
    end
    return r;
  endfunction

  // Lane pattern for one multiplexed word
  function automatic logic [W-1:0] mux(input logic [W-1:0] w, input logic k,
                                       input logic code);
    logic [W-1:0] r;
    r = code ? {1'b0, k, w[7:0]} : w;
    return r;
  endfunction

  // Lane pattern for a given edge
  function automatic logic [W-1:0] lane_pat(input logic [1:0] mode, input logic code,
                                            input logic rise, input logic [W-1:0] a,
                                            input logic [W-1:0] b, input logic ka,
                                            input logic kb);
    logic [W-1:0] r;
    if (mode == rxddr_pkg::MODE_NIBBLE) begin
      r = {nib(b, kb, rise, code), nib(a, ka, rise, code)};
    end else begin
      r = rise ? mux(b, kb, code) : mux(a, ka, code);
    end
    return r;
  endfunction

  // Compensation may be off only outside multiplexed mode
  assign ctc_eff = s_q.clock_tolerance_compensation || (s_q.mode == rxddr_pkg::MODE_MUX);
  // Reference copy when compensating, else channel A divided by ten
  assign shared_nxt = ctc_eff ? !s_q.shared
                              : (s_q.div[0] ^ (s_q.sync2[0] && !s_q.prev[0]
                                 && s_q.cnt[0] == 3'(rxddr_pkg::REC_HALF - 1)));
  assign first_slot = (s_q.mode == rxddr_pkg::MODE_NIBBLE) ? !shared_nxt : shared_nxt;
  assign tick = (shared_nxt != s_q.shared);
  assign f_pop = tick && first_slot && f_valid;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // Recovered clock synchronisers and dividers
    s_d.sync1 = rec_clk_in;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    for (int i = 0; i < N; i++) begin
      if (s_q.sync2[i] && !s_q.prev[i]) begin
        if (s_q.cnt[i] == 3'(rxddr_pkg::REC_HALF - 1)) begin
          s_d.cnt[i] = '0;
          s_d.div[i] = !s_q.div[i];
        end else begin
          s_d.cnt[i] = s_q.cnt[i] + 3'h1;
        end
      end
    end
    // Shared receive clock
    s_d.shared = shared_nxt;
    // Per-channel receive clocks
    for (int i = 0; i < N; i++) begin
      if (s_q.mode == rxddr_pkg::MODE_MUX) begin
        s_d.pco[i] = (i % 2 == 0) ? !s_d.shared : s_d.shared;
      end else if (ctc_eff) begin
        s_d.pco[i] = s_d.shared;
      end else begin
        s_d.pco[i] = s_d.div[i];
      end
    end
    // Lane sequencer, lanes change only at clock edges
    if (tick) begin
      case (s_q.st)
        rxddr_pkg::ST_IDLE, rxddr_pkg::ST_SECOND: begin
          if (first_slot) begin
            if (f_valid) begin
              {s_d.cur_kb, s_d.cur_ka, s_d.cur_b, s_d.cur_a} = f_data;
              s_d.st = rxddr_pkg::ST_FIRST;
            end else begin
              s_d.cur_a = '0;
              s_d.cur_b = '0;
              s_d.cur_ka = 1'b0;
              s_d.cur_kb = 1'b0;
              s_d.st = rxddr_pkg::ST_IDLE;
              if (s_q.st == rxddr_pkg::ST_SECOND) begin
                s_d.underruns = s_q.underruns + 16'h1;
              end
            end
          end
        end
        rxddr_pkg::ST_FIRST: begin
          if (!first_slot) begin
            s_d.st = rxddr_pkg::ST_SECOND;
          end
        end
        default: begin
          s_d.st = rxddr_pkg::ST_IDLE;
        end
      endcase
      s_d.lanes = lane_pat(s_q.mode, s_q.code, s_d.shared, s_d.cur_a, s_d.cur_b,
                           s_d.cur_ka, s_d.cur_kb);
    end
    // Register bus
    s_d.ack = (avs_read || avs_write) && !s_q.ack;
    if (avs_read && !s_q.ack) begin
      case (avs_address)
        rxddr_pkg::OFF_CTRL: begin
          s_d.rdata = '0;
          s_d.rdata[rxddr_pkg::CTRL_MODE_LSB +: 2] = s_q.mode;
          s_d.rdata[rxddr_pkg::CTRL_CODE_BIT] = s_q.code;
          s_d.rdata[rxddr_pkg::CTRL_CTC_BIT] = s_q.clock_tolerance_compensation;
        end
        rxddr_pkg::OFF_STATUS: begin
          s_d.rdata = '0;
          s_d.rdata[rxddr_pkg::STAT_STATE_LSB +: 3] = s_q.st;
          s_d.rdata[rxddr_pkg::STAT_LEVEL_LSB +: LW] = f_level;
          s_d.rdata[rxddr_pkg::STAT_EMPTY_BIT] = !f_valid;
          s_d.rdata[rxddr_pkg::STAT_FULL_BIT] = !word_ready;
        end
        rxddr_pkg::OFF_UNDERRUN: begin
          s_d.rdata = {16'h0, s_q.underruns};
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
    if (avs_write && s_q.ack) begin
      if (avs_address == rxddr_pkg::OFF_CTRL && avs_byteenable[0]) begin
        s_d.mode = avs_writedata[rxddr_pkg::CTRL_MODE_LSB +: 2];
        s_d.code = avs_writedata[rxddr_pkg::CTRL_CODE_BIT];
        s_d.clock_tolerance_compensation = avs_writedata[rxddr_pkg::CTRL_CTC_BIT];
      end
      if (avs_address == rxddr_pkg::OFF_UNDERRUN && avs_byteenable[0]) begin
        // An underrun in the clearing cycle is kept
        s_d.underruns = (s_d.underruns != s_q.underruns) ? 16'h1 : 16'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  assign avs_readdata = s_q.rdata;
  assign chan_h_rx_clock_out = s_q.shared;
  assign per_channel_rx_clock_out = s_q.pco;
  assign rx_lane_ab_byte = s_q.lanes[7:0];
  assign rx_lane_ab_bit8_kflag = s_q.lanes[8];
  assign rx_lane_ab_bit9 = s_q.lanes[9];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  logic nib_q;
  logic mux_q;
  logic ctc_q;
  assign nib_q = (s_q.mode == rxddr_pkg::MODE_NIBBLE);
  assign mux_q = (s_q.mode == rxddr_pkg::MODE_MUX);
  assign ctc_q = s_q.clock_tolerance_compensation || mux_q;

  sequence s_rise;
    $rose(s_q.shared);
  endsequence
  sequence s_fall;
    $fell(s_q.shared);
  endsequence
  sequence s_cfg_steady;
    $stable(s_q.mode) && $stable(s_q.code);
  endsequence

  property p_ref_toggle;
    ctc_q && $past(ctc_q) && !$past(reset) |-> s_q.shared != $past(s_q.shared);
  endproperty
  a_ref_toggle: assert property (p_ref_toggle) else $error("shared clock not ref copy");

  property p_rec_edge;
    !ctc_q && $past(!ctc_q) && !$past(ctc_q, 2) && $changed(s_q.shared) |->
      $past(s_q.sync2[0] && !s_q.prev[0]) && $past(s_q.cnt[0]) == 3'(rxddr_pkg::REC_HALF - 1);
  endproperty
  a_rec_edge: assert property (p_rec_edge) else $error("shared clock not recovered div");

  property p_mux_clocks;
    ##1 mux_q && $past(mux_q) |-> s_q.pco[6] == !s_q.shared && s_q.pco[1] == s_q.shared
      && s_q.pco[0] == !s_q.shared;
  endproperty
  a_mux_clocks: assert property (p_mux_clocks) else $error("mux clock pairs wrong");

  property p_ctc_copies;
    ##1 !mux_q && s_q.clock_tolerance_compensation && $past(!mux_q && s_q.clock_tolerance_compensation) |-> s_q.pco == {N{s_q.shared}};
  endproperty
  a_ctc_copies: assert property (p_ctc_copies) else $error("channel clocks not copies");

  property p_lanes_on_edge;
    !$changed(s_q.shared) |-> $stable(s_q.lanes);
  endproperty
  a_lanes_on_edge: assert property (p_lanes_on_edge) else $error("lanes moved off edge");

  property p_nib_low;
    s_fall ##0 s_cfg_steady ##0 (nib_q && !s_q.code) |->
      s_q.lanes == {s_q.cur_b[4:0], s_q.cur_a[4:0]};
  endproperty
  a_nib_low: assert property (p_nib_low) else $error("nibble low half wrong");

  property p_nib_high;
    s_rise ##0 s_cfg_steady ##0 (nib_q && !s_q.code) |->
      s_q.lanes == {s_q.cur_b[9:5], s_q.cur_a[9:5]};
  endproperty
  a_nib_high: assert property (p_nib_high) else $error("nibble high half wrong");

  property p_nib_kflag;
    s_rise ##0 s_cfg_steady ##0 (nib_q && s_q.code) |->
      s_q.lanes[3] == s_q.cur_ka && s_q.lanes[8] == s_q.cur_kb;
  endproperty
  a_nib_kflag: assert property (p_nib_kflag) else $error("nibble K flags wrong");

  property p_mux_b_rise;
    s_rise ##0 s_cfg_steady ##0 !nib_q |-> s_q.lanes[7:0] == s_q.cur_b[7:0]
      && s_q.lanes[8] == (s_q.code ? s_q.cur_kb : s_q.cur_b[8]);
  endproperty
  a_mux_b_rise: assert property (p_mux_b_rise) else $error("channel B not on rise");

  property p_mux_a_fall;
    s_fall ##0 s_cfg_steady ##0 !nib_q |-> s_q.lanes[7:0] == s_q.cur_a[7:0]
      && s_q.lanes[9] == (s_q.code ? 1'b0 : s_q.cur_a[9]);
  endproperty
  a_mux_a_fall: assert property (p_mux_a_fall) else $error("channel A not on fall");

endmodule

// >>> dv/rxddr_proto_sink.sv
`timescale 1ns/1ps
// ----------------------------------------
// Protocol device latching the A/B lanes
// ----------------------------------------
module rxddr_proto_sink (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Receive clocks and lanes
  input wire logic rx_clk,
  input wire logic [6:0] per_clk,
  input wire logic [9:0] lanes,
  // Latched values
  output logic edge_seen,
  output logic edge_rise,
  output logic [9:0] edge_data,
  output logic [6:0] edge_per
);
  logic prev_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prev_q <= 1'b0;
      edge_seen <= 1'b0;
      edge_rise <= 1'b0;
      edge_data <= 10'h000;
      edge_per <= 7'h00;
    end else begin
      prev_q <= rx_clk;
      edge_seen <= rx_clk != prev_q;
      edge_rise <= rx_clk;
      edge_data <= lanes;
      edge_per <= per_clk;
    end
  end
endmodule

// >>> dv/rx_ddr_parallel_output_ab_bench.sv
`timescale 1ns/1ps
module rx_ddr_parallel_output_ab_bench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic rclk = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, word_ready, kflag_a = 1'b0, kflag_b = 1'b0, word_valid = 1'b0;
  logic [9:0] word_a = 10'h000, word_b = 10'h000, edge_data;
  logic chan_h_rx_clock_out, rx_lane_ab_bit8_kflag, rx_lane_ab_bit9, edge_seen, edge_rise;
  logic [6:0] per_channel_rx_clock_out, edge_per;
  logic [7:0] rx_lane_ab_byte;
  logic [10:0] exp_q[$];
  logic [10:0] e;
  logic [31:0] d, u;
  logic [1:0] cur_mode;
  logic cur_code, cur_ctc, started = 1'b0, stalled = 1'b0;
  int fails = 0, n_tests = 0, cycles = 0, seed = 32'h268b0dbb;
  realtime last_t = 0;

  always #20 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #160 rclk = ~rclk;
  end

  rxddr_top DUT (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .word_valid(word_valid), .word_ready(word_ready),
    .word_a(word_a), .word_b(word_b), .kflag_a(kflag_a), .kflag_b(kflag_b),
    .rec_clk_in({7{rclk}}), .chan_h_rx_clock_out(chan_h_rx_clock_out),
    .per_channel_rx_clock_out(per_channel_rx_clock_out), .rx_lane_ab_byte(rx_lane_ab_byte),
    .rx_lane_ab_bit8_kflag(rx_lane_ab_bit8_kflag), .rx_lane_ab_bit9(rx_lane_ab_bit9));

  rxddr_proto_sink SINK (.ref_clk(ref_clk), .reset(reset), .rx_clk(chan_h_rx_clock_out),
    .per_clk(per_channel_rx_clock_out),
    .lanes({rx_lane_ab_bit9, rx_lane_ab_bit8_kflag, rx_lane_ab_byte}),
    .edge_seen(edge_seen), .edge_rise(edge_rise), .edge_data(edge_data), .edge_per(edge_per));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  always @(posedge ref_clk) begin
    if (edge_seen === 1'b1) begin
      if (!started && edge_data !== 10'h000) started = 1'b1;
      if (started && exp_q.size() > 0) begin
        e = exp_q.pop_front();
        chk({edge_rise, edge_data} === e, "lane data");
        if (cur_mode == rxddr_pkg::MODE_MUX) begin
          chk(edge_per === (edge_rise ? 7'h2A : 7'h55), "paired clocks");
        end else if (cur_ctc) begin
          chk(edge_per === {7{edge_rise}}, "reference clocks");
        end else begin
          chk(edge_per === {7{edge_rise}}, "channel div clocks");
          if (last_t > 0) begin
            chk(($realtime - last_t) >= 1520 && ($realtime - last_t) <= 1680, "div clock");
          end
        end
        last_t = $realtime;
      end
    end
  end

  // ----------------------------------------
  // Bus and stream drivers
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic set_ctrl(input logic [31:0] v);
    bus(1'b1, rxddr_pkg::OFF_CTRL, v, 4'hF, u);
    cur_mode = v[1:0];
    cur_code = v[2];
    cur_ctc = v[3] | (v[1:0] == rxddr_pkg::MODE_MUX);
  endtask

  task automatic burst(input int cnt);
    logic [31:0] r;
    logic [9:0] a, b;
    logic ka, kb;
    int n;
    started = 1'b0;
    last_t = 0;
    for (int i = 0; i < cnt; i++) begin
      r = $random(seed);
      a = r[9:0] | 10'h001;
      b = r[19:10] | 10'h001;
      ka = r[20];
      kb = r[21];
      word_a <= a;
      word_b <= b;
      kflag_a <= ka;
      kflag_b <= kb;
      word_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (word_ready !== 1'b1 && n < 5000);
      if (n > 1) stalled = 1'b1;
      if (cur_mode != rxddr_pkg::MODE_NIBBLE && !cur_code) begin
        exp_q.push_back({1'b1, b});
        exp_q.push_back({1'b0, a});
      end else if (cur_mode != rxddr_pkg::MODE_NIBBLE) begin
        exp_q.push_back({2'b10, kb, b[7:0]});
        exp_q.push_back({2'b00, ka, a[7:0]});
      end else if (!cur_code) begin
        exp_q.push_back({1'b0, b[4:0], a[4:0]});
        exp_q.push_back({1'b1, b[9:5], a[9:5]});
      end else begin
        exp_q.push_back({2'b00, b[3:0], 1'b0, a[3:0]});
        exp_q.push_back({1'b1, b[7], kb, b[6:4], a[7], ka, a[6:4]});
      end
    end
    word_valid <= 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(exp_q.size() == 0, "words not all seen");
    $display("test burst mode %0d done", cur_mode);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, rxddr_pkg::OFF_CTRL, 32'h0, 4'h0, d);
    chk(d === 32'h0000_0008, "control reset");
    bus(1'b0, rxddr_pkg::OFF_STATUS, 32'h0, 4'h0, d);
    chk(d === 32'h0000_0101, "status reset");
    bus(1'b0, 4'hC, 32'h0, 4'h0, d);
    chk(d === 32'h0, "unmapped read");
    $display("test registers done");
    set_ctrl(32'h1);
    burst(4);
    set_ctrl(32'hD);
    burst(4);
    set_ctrl(32'hA);
    burst(4);
    set_ctrl(32'h8);
    burst(4);
    set_ctrl(32'hC);
    burst(4);
    set_ctrl(32'h0);
    burst(10);
    chk(stalled, "stream never refused");
    bus(1'b0, rxddr_pkg::OFF_UNDERRUN, 32'h0, 4'h0, d);
    chk(d[15:0] !== 16'h0, "underrun count");
    bus(1'b1, rxddr_pkg::OFF_UNDERRUN, 32'h0, 4'h0, u);
    bus(1'b0, rxddr_pkg::OFF_UNDERRUN, 32'h0, 4'h0, u);
    chk(u === d, "masked clear");
    bus(1'b1, rxddr_pkg::OFF_UNDERRUN, 32'h0, 4'h1, u);
    bus(1'b0, rxddr_pkg::OFF_UNDERRUN, 32'h0, 4'h0, u);
    chk(u[15:0] === 16'h0, "underrun clear");
    $display("test underrun done");
    finish_test();
  end
endmodule
